// ---- amu_top.sv ----
/*
  Address decode and fetch-and-op unit of a node memory hub. Takes one
  uncached or cached request at a time, decodes the address space, and
  runs atomic read-modify-write against a fixed-latency memory port.
  Assumes the memory answers rdata exactly MEM_LAT cycles after a read
  strobe and that non-atomic spaces are served by other hub logic.
*/
// Summary of operation
// - Space code 10 is atomic; route by node identifier field.
// - Bit 49 zero, node id 48:38, 36-bit offset 35:0.
// - Atomic ops only word or doubleword, uncached loads and stores.
// - Variable works as one 64-bit or two 32-bit quantities.
// - Offset bits 5:3 choose the atomic operation.
// - Fetch returns value unmodified.
// - Fetch-and-increment returns old value then writes value plus one.
// - Fetch-and-decrement returns old value then writes value minus one.
// - Fetch-and-clear returns old value then writes zero.
// - Initialize stores supplied data unchanged.
// - Increment write adds one to stored value.
// - Decrement write subtracts one from stored value.
// - AND write stores bitwise AND of value and data.
// - OR write stores bitwise OR of value and data.
// - Space code 11 is ordinary memory with UC, WB, WC attributes.
// - Code 00 local or global split by bit 35; 01 is get space.
module amu_top
  import amu_pkg::*;
#(
  parameter logic [NODE_W-1:0] MY_NODE = 11'h0
)(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  // Request from processors
  input  wire logic              req_valid_i,
  input  wire amu_req_t          req_i,
  output logic                   req_ready_o,
  // Response to processors
  output logic                   rsp_valid_o,
  output amu_rsp_t               rsp_o,
  // Forwarding of non-local or non-atomic requests
  output logic                   fwd_valid_o,
  output logic [2:0]             fwd_dst_o,
  output amu_req_t               fwd_req_o,
  // Memory port
  output logic                   mem_rd_o,
  output logic                   mem_wr_o,
  output logic [OFS_W-1:0]       mem_addr_o,
  output logic [DATA_W-1:0]      mem_wdata_o,
  input  wire logic [DATA_W-1:0] mem_rdata_i
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_READ = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_WBK  = 4'b1000
  } amu_state_t;

  amu_state_t        state_q, state_d;
  amu_req_t          cur_q;
  logic [1:0]        cnt_q;
  logic [DATA_W-1:0] old_q;
  logic              rsp_valid_q;
  amu_rsp_t          rsp_q;
  logic              fwd_valid_q;
  logic [2:0]        fwd_dst_q;
  amu_req_t          fwd_req_q;
  logic              mem_rd_q;
  logic              mem_wr_q;
  logic [OFS_W-1:0]  mem_addr_q;
  logic [DATA_W-1:0] mem_wdata_q;

  // Decode is a function, though only the incoming request uses it
  function automatic logic [2:0] space_of(input logic [PA_W-1:0] a);
    logic [2:0] d;
    d = DST_MEMORY;
    if (a[AS_HI:AS_LO] == AS_ATOMIC) begin
      d = DST_ATOMIC;
    end else if (a[AS_HI:AS_LO] == AS_GET) begin
      d = DST_GET;
    end else if (a[AS_HI:AS_LO] == AS_LOCAL) begin
      d = a[SPLIT_BIT] ? DST_GLOBAL : DST_LOCAL;
    end
    return d;
  endfunction

  wire        take      = req_valid_i & req_ready_o;
  wire [2:0]  in_dst    = space_of(req_i.addr);
  wire        in_home   = req_i.addr[NODE_HI:NODE_LO] == MY_NODE;
  wire        in_bad_pa = req_i.addr[PA_TOP];
  // Atomic targets: first dword of a 64-byte block, uncached only
  wire        in_atomic = (in_dst == DST_ATOMIC) & in_home;
  wire        in_amo_ok = ~req_i.cached &
                          (req_i.dword ? ~req_i.addr[WORD_BIT] : 1'b1);
  wire        in_attr_ok = req_i.attr == ATTR_UC | req_i.attr == ATTR_WB |
                           req_i.attr == ATTR_WC;
  // Access-mode checks: one caching mode for get and global, attribute for memory
  wire        in_mode_ok =
      (in_dst == DST_GET)    ?  req_i.cached :
      (in_dst == DST_GLOBAL) ? ~req_i.cached :
      (in_dst == DST_MEMORY) ?  in_attr_ok  : 1'b1;

  logic [DATA_W-1:0] alu_new;
  logic              alu_wb;
  logic              alu_bad;
  amu_alu u_alu_mem (
    .write_i (cur_q.write),
    .op_i    (cur_q.addr[OP_HI:OP_LO]),
    .dword_i (cur_q.dword),
    .hi_i    (cur_q.addr[WORD_BIT]),
    .old_i   (mem_rdata_i),
    .wdata_i (cur_q.wdata),
    .new_o   (alu_new),
    .wb_o    (alu_wb),
    .bad_o   (alu_bad)
  );

  // Busy until writeback done, so no request slips between read and write
  assign req_ready_o = (state_q == ST_IDLE);

  // Sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (take && in_atomic && in_amo_ok && !in_bad_pa) begin
        state_d = ST_READ;
      end
      ST_READ: state_d = ST_WAIT;
      ST_WAIT: if (cnt_q == MEM_LAT) begin
        state_d = ST_WBK;
      end
      ST_WBK:  state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_q     <= ST_IDLE;
      cur_q       <= '0;
      cnt_q       <= 2'h0;
      old_q       <= '0;
      rsp_valid_q <= 1'b0;
      rsp_q       <= '0;
      fwd_valid_q <= 1'b0;
      fwd_dst_q   <= DST_LOCAL;
      fwd_req_q   <= '0;
      mem_rd_q    <= 1'b0;
      mem_wr_q    <= 1'b0;
      mem_addr_q  <= '0;
      mem_wdata_q <= '0;
    end else begin
      state_q     <= state_d;
      rsp_valid_q <= 1'b0;
      fwd_valid_q <= 1'b0;
      mem_rd_q    <= 1'b0;
      mem_wr_q    <= 1'b0;
      cnt_q       <= (state_q == ST_WAIT) ? cnt_q + 2'h1 : 2'h1;
      if (state_q == ST_IDLE && take) begin
        cur_q <= req_i;
        if (in_bad_pa || !in_mode_ok ||
            (in_atomic && !in_amo_ok)) begin
          rsp_valid_q <= 1'b1; // Refused with error, nothing touched
          rsp_q       <= '{rdata: '0, err: 1'b1};
        end else if (!in_atomic) begin
          fwd_valid_q <= 1'b1; // Other spaces and other nodes go on
          fwd_dst_q   <= in_dst;
          fwd_req_q   <= req_i;
        end
      end
      if (state_q == ST_READ) begin
        mem_rd_q   <= 1'b1;
        mem_addr_q <= {cur_q.addr[OFS_W-1:BLK_HI+1], {(BLK_HI+1){1'b0}}};
      end
      // Old value answered (zero for writes) and any new value written, both strobed in the next cycle
      if (state_q == ST_WAIT && cnt_q == MEM_LAT) begin
        old_q       <= mem_rdata_i;
        rsp_valid_q <= 1'b1;
        rsp_q       <= '{rdata: cur_q.write ? 64'h0 : mem_rdata_i,
                         err: alu_bad};
        mem_wr_q    <= alu_wb;
        mem_wdata_q <= alu_new;
      end
    end
  end

  assign rsp_valid_o = rsp_valid_q;
  assign rsp_o       = rsp_q;
  assign fwd_valid_o = fwd_valid_q;
  assign fwd_dst_o   = fwd_dst_q;
  assign fwd_req_o   = fwd_req_q;
  assign mem_rd_o    = mem_rd_q;
  assign mem_wr_o    = mem_wr_q;
  assign mem_addr_o  = mem_addr_q;
  assign mem_wdata_o = mem_wdata_q;

  // Atomic request is answered a fixed time after it is taken
  sequence s_amo_take;
    take && in_atomic && in_amo_ok && !in_bad_pa;
  endsequence
  property p_amo_answer;
    @(posedge clk_i) disable iff (!rstn_i)
      s_amo_take |=> ##1 mem_rd_o ##2 rsp_valid_o ##1 state_q == ST_IDLE;
  endproperty
  a_amo_answer: assert property (p_amo_answer)
    else $error("atomic request not answered on time");

  property p_busy;
    @(posedge clk_i) disable iff (!rstn_i)
      mem_rd_o |-> !req_ready_o [*3];
  endproperty
  a_busy: assert property (p_busy)
    else $error("request taken during read-modify-write");

  property p_wr_follows_rd;
    @(posedge clk_i) disable iff (!rstn_i)
      mem_wr_o |-> $past(mem_rd_o, 2);
  endproperty
  a_wr_follows_rd: assert property (p_wr_follows_rd)
    else $error("write-back without its read");

  property p_fetch_nowrite;
    @(posedge clk_i) disable iff (!rstn_i)
      (mem_rd_o && !cur_q.write && cur_q.addr[OP_HI:OP_LO] == OPR_FETCH)
      |-> ##2 !mem_wr_o;
  endproperty
  a_fetch_nowrite: assert property (p_fetch_nowrite)
    else $error("plain fetch modified memory");

  property p_clear_zero;
    @(posedge clk_i) disable iff (!rstn_i)
      (mem_wr_o && cur_q.dword && !cur_q.write &&
       cur_q.addr[OP_HI:OP_LO] == OPR_CLEAR) |-> mem_wdata_o == 64'h0;
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("clear wrote non-zero value");

  property p_inc_value;
    @(posedge clk_i) disable iff (!rstn_i)
      (mem_wr_o && cur_q.dword && cur_q.addr[OP_HI:OP_LO] == OPR_INC)
      |-> mem_wdata_o == old_q + 64'h1;
  endproperty
  a_inc_value: assert property (p_inc_value)
    else $error("increment wrote wrong value");

  property p_dec_value;
    @(posedge clk_i) disable iff (!rstn_i)
      (mem_wr_o && cur_q.dword && cur_q.addr[OP_HI:OP_LO] == OPR_DEC)
      |-> mem_wdata_o == old_q - 64'h1;
  endproperty
  a_dec_value: assert property (p_dec_value)
    else $error("decrement wrote wrong value");

  property p_fwd_space;
    @(posedge clk_i) disable iff (!rstn_i)
      (take && in_dst == DST_GET && !req_i.cached)
      |=> rsp_valid_o && rsp_o.err && !fwd_valid_o;
  endproperty
  a_fwd_space: assert property (p_fwd_space)
    else $error("uncached get access not refused");

endmodule

// ---- amu_pkg.sv ----
/*
  Package for the atomic memory operation unit: address fields, space
  codes, operation codes, request and response carriers, timing figures.
  Assumes a single 10 MHz clock domain and a 64-bit memory data path.
*/
package amu_pkg;

  // Physical address layout
  localparam int unsigned PA_W       = 50;
  localparam int unsigned PA_TOP     = 49;
  localparam int unsigned NODE_HI    = 48;
  localparam int unsigned NODE_LO    = 38;
  localparam int unsigned NODE_W     = 11;
  localparam int unsigned AS_HI      = 37;
  localparam int unsigned AS_LO      = 36;
  localparam int unsigned OFS_W      = 36;
  localparam int unsigned SPLIT_BIT  = 35;
  localparam int unsigned OP_HI      = 5;
  localparam int unsigned OP_LO      = 3;
  localparam int unsigned BLK_HI     = 5;
  localparam int unsigned WORD_BIT   = 2;
  localparam int unsigned DATA_W     = 64;
  localparam int unsigned HALF_W     = 32;

  // Address-space codes
  localparam logic [1:0] AS_LOCAL    = 2'h0;
  localparam logic [1:0] AS_GET      = 2'h1;
  localparam logic [1:0] AS_ATOMIC   = 2'h2;
  localparam logic [1:0] AS_MEMORY   = 2'h3;

  // Atomic operation codes in offset bits 5:3
  localparam logic [2:0] OPR_FETCH   = 3'h0;
  localparam logic [2:0] OPR_INC     = 3'h1;
  localparam logic [2:0] OPR_DEC     = 3'h2;
  localparam logic [2:0] OPR_CLEAR   = 3'h3;
  localparam logic [2:0] OPW_INIT    = 3'h0;
  localparam logic [2:0] OPW_INC     = 3'h1;
  localparam logic [2:0] OPW_DEC     = 3'h2;
  localparam logic [2:0] OPW_AND     = 3'h3;
  localparam logic [2:0] OPW_OR      = 3'h4;

  // Memory attribute codes for ordinary memory space
  localparam logic [1:0] ATTR_UC     = 2'h0;
  localparam logic [1:0] ATTR_WB     = 2'h1;
  localparam logic [1:0] ATTR_WC     = 2'h2;

  // Decoded destination of a request
  localparam logic [2:0] DST_LOCAL   = 3'h0;
  localparam logic [2:0] DST_GLOBAL  = 3'h1;
  localparam logic [2:0] DST_GET     = 3'h2;
  localparam logic [2:0] DST_ATOMIC  = 3'h3;
  localparam logic [2:0] DST_MEMORY  = 3'h4;

  // Fixed latency of the memory behind the unit, in ns and in clock cycles
  localparam int unsigned CLK_NS     = 100;
  localparam int unsigned MEM_LAT_NS = 200;
  localparam int unsigned MEM_LAT_CY =
    (MEM_LAT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] MEM_LAT    = 2'(MEM_LAT_CY);

  typedef struct packed {
    logic [PA_W-1:0]   addr;
    logic              write;
    logic              dword;   // 1: 64-bit, 0: 32-bit
    logic              cached;
    logic [1:0]        attr;
    logic [DATA_W-1:0] wdata;
  } amu_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic              err;
  } amu_rsp_t;

endpackage

// ---- amu_alu.sv ----
/*
  Combinational fetch-and-op arithmetic for the atomic unit.
  Assumes its caller holds the read value and applies the result.
*/
module amu_alu
  import amu_pkg::*;
(
  // Operation select
  input  wire logic              write_i,
  input  wire logic [2:0]        op_i,
  input  wire logic              dword_i,
  input  wire logic              hi_i,
  // Operands
  input  wire logic [DATA_W-1:0] old_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  // Result
  output logic [DATA_W-1:0]      new_o,
  output logic                   wb_o,
  output logic                   bad_o
);

  logic [DATA_W-1:0] full_res;
  logic [HALF_W-1:0] half_old;
  logic [HALF_W-1:0] half_wd;
  logic [HALF_W-1:0] half_res;
  logic              chg;
  logic              unk;

  // 32-bit lane follows address bit 2; the other lane stays put
  assign half_old = hi_i ? old_i[DATA_W-1:HALF_W] : old_i[HALF_W-1:0];
  assign half_wd  = hi_i ? wdata_i[DATA_W-1:HALF_W] : wdata_i[HALF_W-1:0];

  // Operation table, applied at either width
  always_comb begin
    full_res = old_i;
    half_res = half_old;
    chg      = 1'b0;
    unk      = 1'b0;
    if (!write_i) begin
      case (op_i)
        OPR_FETCH: chg = 1'b0;
        OPR_INC: begin
          full_res = old_i + 64'h1;
          half_res = half_old + 32'h1;
          chg      = 1'b1;
        end
        OPR_DEC: begin
          full_res = old_i - 64'h1;
          half_res = half_old - 32'h1;
          chg      = 1'b1;
        end
        OPR_CLEAR: begin
          full_res = '0;
          half_res = '0;
          chg      = 1'b1;
        end
        default: unk = 1'b1;
      endcase
    end else begin
      chg = 1'b1;
      case (op_i)
        OPW_INIT: begin
          full_res = wdata_i;
          half_res = half_wd;
        end
        OPW_INC: begin
          full_res = old_i + 64'h1;
          half_res = half_old + 32'h1;
        end
        OPW_DEC: begin
          full_res = old_i - 64'h1;
          half_res = half_old - 32'h1;
        end
        OPW_AND: begin
          full_res = old_i & wdata_i;
          half_res = half_old & half_wd;
        end
        OPW_OR: begin
          full_res = old_i | wdata_i;
          half_res = half_old | half_wd;
        end
        default: begin
          chg = 1'b0;
          unk = 1'b1;
        end
      endcase
    end
  end

  // Two independent halves or one 64-bit variable
  assign new_o = dword_i ? full_res :
                 hi_i ? {half_res, old_i[HALF_W-1:0]} :
                        {old_i[DATA_W-1:HALF_W], half_res};
  assign wb_o  = chg & ~unk;
  assign bad_o = unk;

endmodule

// ---- amu_mem_model.sv ----
/*
  Memory partner for the atomic unit: a sparse word store that answers a
  read strobe after a fixed delay and scrambles its data lines otherwise.
  Assumes one-cycle registered strobes from the unit on clk_i.
*/
module amu_mem_model
  import amu_pkg::*;
(
  // Clock
  input  wire logic              clk_i,
  // Strobes and address from the unit
  input  wire logic              rd_i,
  input  wire logic              wr_i,
  input  wire logic [OFS_W-1:0]  addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  // Read data back to the unit
  output logic [DATA_W-1:0]      rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [DATA_W-1:0] mem [logic [OFS_W-1:0]];
  int                hold_q = 0;

  initial rdata_o = '0;

  // Data stands a short while after a read, then toggles so stale
  // values can never pass for a fresh answer
  always @(posedge clk_i) begin
    if (wr_i) begin
      mem[addr_i] = wdata_i;
    end
    if (rd_i) begin
      rdata_o <= mem.exists(addr_i) ? mem[addr_i] : '0;
      hold_q  <= 3;
    end else if (hold_q > 0) begin
      hold_q <= hold_q - 1;
    end else begin
      rdata_o <= ~rdata_o;
    end
  end
endmodule

// ---- amu_top_test.sv ----
/*
  Self-checking bench for the atomic unit: drives processor requests,
  keeps a shadow memory, and checks answers, writes and forwards.
  Assumes the memory partner model and registered one-cycle strobes.
*/
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h expected %h", $time, g, e); end end

module amu_top_test
  import amu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [NODE_W-1:0] NODE = 11'h02a;

  logic              clk_i = 1'b0;
  logic              rstn_i = 1'b0;
  logic              req_valid_i = 1'b0;
  amu_req_t          req_i = '0;
  logic              req_ready_o, rsp_valid_o, fwd_valid_o;
  logic              mem_rd_o, mem_wr_o;
  amu_rsp_t          rsp_o;
  logic [2:0]        fwd_dst_o;
  amu_req_t          fwd_req_o;
  logic [OFS_W-1:0]  mem_addr_o;
  logic [DATA_W-1:0] mem_wdata_o, mem_rdata_i;
  int                num_errors = 0;
  int                comparisons = 0;
  int                cycles = 0;
  logic [DATA_W-1:0] shadow [logic [OFS_W-1:0]];
  logic [64:0]       rsp_q[$];
  logic [63:0]       msk_q[$];
  logic [99:0]       wr_q[$];
  logic [2:0]        dst_q[$];
  amu_req_t          fwd_q[$];
  logic [64:0]       exp_r;
  logic [63:0]       exp_m;
  logic [99:0]       exp_w;
  logic [2:0]        exp_d;
  amu_req_t          exp_f;
  amu_req_t          r;

  amu_top #(.MY_NODE(NODE)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_o(rsp_o), .fwd_valid_o(fwd_valid_o), .fwd_dst_o(fwd_dst_o),
    .fwd_req_o(fwd_req_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(mem_rdata_i));

  amu_mem_model mdl (
    .clk_i(clk_i), .rd_i(mem_rd_o), .wr_i(mem_wr_o), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

  // Free-running 10 MHz clock
  initial forever #50 clk_i = ~clk_i;

  // Hang guard; the run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // Output watcher: every strobe takes the oldest note of its kind
  always @(posedge clk_i) begin
    if (rstn_i && rsp_valid_o === 1'b1) begin
      `CHK(rsp_q.size() > 0, 1'b1)
      if (rsp_q.size() > 0) begin
        exp_r = rsp_q.pop_front();
        exp_m = msk_q.pop_front();
        `CHK(rsp_o.err, exp_r[64])
        `CHK(rsp_o.rdata & exp_m, exp_r[63:0] & exp_m)
      end
    end
    if (rstn_i && mem_wr_o === 1'b1) begin
      `CHK(wr_q.size() > 0, 1'b1)
      if (wr_q.size() > 0) begin
        // Popped once here, as the macro names its arguments twice
        exp_w = wr_q.pop_front();
        `CHK({mem_addr_o, mem_wdata_o}, exp_w)
      end
    end
    if (rstn_i && fwd_valid_o === 1'b1) begin
      `CHK(fwd_q.size() > 0, 1'b1)
      if (fwd_q.size() > 0) begin
        exp_d = dst_q.pop_front();
        exp_f = fwd_q.pop_front();
        `CHK(fwd_dst_o, exp_d)
        `CHK(fwd_req_o, exp_f)
      end
    end
  end

  // Holds valid until taken; a non-last call leaves it up for the next
  task automatic send(amu_req_t q, bit last);
    int n;
    n = 0;
    req_valid_i <= 1'b1;
    req_i       <= q;
    do @(posedge clk_i); while (req_ready_o !== 1'b1 && ++n < 50);
    if (last) begin
      req_valid_i <= 1'b0;
      n = 0;
      while (rsp_q.size() + wr_q.size() + fwd_q.size() != 0 && n++ < 20)
        @(posedge clk_i);
      @(posedge clk_i);
    end
  endtask

  function automatic amu_req_t mk(logic [1:0] sp, logic [35:0] ofs,
                                  logic w, logic c);
    amu_req_t q;
    q        = '0;
    q.addr   = {1'b0, NODE, sp, ofs};
    q.write  = w;
    q.dword  = 1'b1;
    q.cached = c;
    q.wdata  = {$urandom, $urandom};
    return q;
  endfunction

  task automatic preload(logic [35:0] a, logic [63:0] v);
    shadow[a]  = v;
    mdl.mem[a] = v;
  endtask

  // One atomic request with its expected answer and write-back
  task automatic atom(logic [29:0] blk, logic [2:0] op, logic w, logic dw,
                      logic hi, bit last);
    amu_req_t    q;
    logic [35:0] a;
    logic [63:0] o, v, n;
    logic        bad;
    a = {blk, 6'h0};
    if (!shadow.exists(a)) preload(a, {$urandom, $urandom});
    q = mk(AS_ATOMIC, a | {op, hi, 2'h0}, w, 1'b0);
    q.dword = dw;
    if (!dw) q.wdata = {2{q.wdata[31:0]}};
    o = shadow[a];
    v = dw ? o : (hi ? {32'h0, o[63:32]} : {32'h0, o[31:0]});
    bad = op > (w ? OPW_OR : OPR_CLEAR);
    case ({w, op})
      {1'b0, OPR_INC}, {1'b1, OPW_INC}: n = v + 64'h1;
      {1'b0, OPR_DEC}, {1'b1, OPW_DEC}: n = v - 64'h1;
      {1'b0, OPR_CLEAR}:                n = 64'h0;
      {1'b1, OPW_INIT}:                 n = q.wdata;
      {1'b1, OPW_AND}:                  n = v & q.wdata;
      {1'b1, OPW_OR}:                   n = v | q.wdata;
      default:                          n = v;
    endcase
    if (!dw) n = hi ? {n[31:0], o[31:0]} : {o[63:32], n[31:0]};
    rsp_q.push_back({bad, (w || bad) ? 64'h0 : o});
    msk_q.push_back(bad ? 64'h0 : {64{1'b1}}); // Word reads return all 64
    if (!bad && (w || op != OPR_FETCH)) begin
      wr_q.push_back({a, n});
      shadow[a] = n;
    end
    send(q, last);
  endtask

  task automatic refuse(amu_req_t q);
    rsp_q.push_back({1'b1, 64'h0});
    msk_q.push_back('0);
    send(q, 1'b1);
  endtask

  task automatic fwd(amu_req_t q, logic [2:0] d, bit last);
    dst_q.push_back(d);
    fwd_q.push_back(q);
    send(q, last);
  endtask

  task automatic tally_and_finish();
    // Notes never answered mean a request was lost or never taken
    if (rsp_q.size() + wr_q.size() + fwd_q.size() != 0) begin
      num_errors++;
    end
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    void'($urandom(5683));
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    `CHK(req_ready_o, 1'b1)
    // Every read and write code, back to back on one variable
    for (int i = 0; i < 16; i++)
      atom(30'h11, 3'(i), i[3], 1'b1, 1'b0, i == 15);
    // Word halves, low half starting at all ones to show the wrap stays put
    preload({30'h23, 6'h0}, 64'h0000_0000_ffff_ffff);
    for (int h = 0; h < 2; h++)
      for (int k = 0; k < 9; k++)
        atom(30'h23, 3'(k < 4 ? k : k - 4), k >= 4, 1'b0, h[0], 1'b1);
    // Random mix on a few blocks, doubleword targets always at offset 0
    for (int i = 0; i < 24; i++) begin
      logic dw;
      dw = 1'($urandom);
      atom(30'($urandom % 4), 3'($urandom % 5), 1'($urandom), dw,
           dw ? 1'b0 : 1'($urandom), 1'b1);
    end
    // Refused requests
    r = mk(AS_ATOMIC, 36'h40, 1'b0, 1'b0);
    r.addr[PA_TOP] = 1'b1;
    refuse(r);
    refuse(mk(AS_ATOMIC, 36'h40, 1'b0, 1'b1));
    refuse(mk(AS_ATOMIC, 36'h44, 1'b1, 1'b0));
    refuse(mk(AS_GET, 36'h80, 1'b0, 1'b0));
    refuse(mk(AS_LOCAL, 36'h8_0000_0080, 1'b1, 1'b1));
    r = mk(AS_MEMORY, 36'h80, 1'b0, 1'b0);
    r.attr = 2'h3;
    refuse(r);
    // Forwarded spaces, memory ones back to back
    for (int k = 0; k < 3; k++) begin
      r = mk(AS_MEMORY, 36'($urandom), k[0], k == 1);
      r.attr = 2'(k);
      fwd(r, DST_MEMORY, k == 2);
    end
    fwd(mk(AS_LOCAL, 36'h100, 1'b1, 1'b1), DST_LOCAL, 1'b1);
    fwd(mk(AS_LOCAL, 36'h8_0000_0100, 1'b0, 1'b0), DST_GLOBAL, 1'b1);
    fwd(mk(AS_GET, 36'h200, 1'b0, 1'b1), DST_GET, 1'b1);
    r = mk(AS_ATOMIC, 36'h40, 1'b0, 1'b0);
    r.addr[NODE_HI:NODE_LO] = NODE + 11'h002;
    fwd(r, DST_ATOMIC, 1'b1);
    tally_and_finish();
  end
endmodule
